// ===== clk_gate_ctl.sv
// Deep sleep port clock gate and soft reset control 0, APB slave.
// Assumes run and sleep gate registers, mode and capability mask come from
// the rest of system control on ref_clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "clk_gate_map.svh"
module clk_gate_ctl
    import clk_gate_pkg::*;
(
    input  wire logic                      ref_clk_i,
    input  wire logic                      arst_n_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [`ADDR_W-1:0]        paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic [31:0]                    prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    input  wire clk_gate_pkg::power_mode_t mode_i,
    input  wire logic                      auto_clock_gating_i,
    input  wire logic [`NUM_PORTS-1:0]     run_port_clock_gate_i,
    input  wire logic [`NUM_PORTS-1:0]     sleep_port_clock_gate_i,
    input  wire logic [31:0]               capability_mask_1_i,
    input  wire logic                      port_access_i,
    input  wire logic [2:0]                port_sel_i,
    output logic                           port_fault_o,
    output logic [`NUM_PORTS-1:0]          port_clk_en_o,
    output clk_gate_pkg::unit_reset_t      unit_reset_o
);
    import clk_gate_pkg::*;

    logic [`NUM_PORTS-1:0] deep_gate_q;
    logic [31:0]           src0_q;
    logic                  wr_en;
    logic                  acc_en;
    gate_set_t             gates;

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    assign acc_en   = psel_i && penable_i;
    assign wr_en    = acc_en && pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = acc_en && !hit(paddr_i, `SRC0_OFFSET)
                              && !hit(paddr_i, `DSGATE_OFFSET);

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            deep_gate_q <= `NUM_PORTS'(`DSGATE_RESET);
        else if (wr_en && hit(paddr_i, `DSGATE_OFFSET))
            deep_gate_q <= pwdata_i[`NUM_PORTS-1:0];
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            src0_q <= `SRC0_RESET;
        else if (wr_en && hit(paddr_i, `SRC0_OFFSET))
            src0_q <= (pwdata_i & capability_mask_1_i & `SRC0_MASK)
                    | (src0_q & ~capability_mask_1_i);
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            prdata_o <= '0;
        else if (psel_i && !penable_i && !pwrite_i)
        begin
            if (hit(paddr_i, `DSGATE_OFFSET))
                prdata_o <= {{(32-`NUM_PORTS){1'b0}}, deep_gate_q};
            else if (hit(paddr_i, `SRC0_OFFSET))
                prdata_o <= src0_q & `SRC0_MASK;
            else
                prdata_o <= '0;
        end
    end

    assign gates = '{run_gate:   run_port_clock_gate_i,
                     sleep_gate: sleep_port_clock_gate_i,
                     deep_gate:  deep_gate_q};

    gate_select u_sel (
        .ref_clk_i           (ref_clk_i),
        .arst_n_i            (arst_n_i),
        .mode_i              (mode_i),
        .auto_clock_gating_i (auto_clock_gating_i),
        .gates_i             (gates),
        .enable_o            (port_clk_en_o)
    );

    // Fault is combinational so the port access answers in its own cycle
    assign port_fault_o = port_access_i && !port_clk_en_o[port_sel_i];

    // Unit resets held while bit set
    assign unit_reset_o = '{conv: src0_q[`SRC0_CONV_BIT],
                            hibernation_reset:  src0_q[`SRC0_HIB_BIT],
                            wdog: src0_q[`SRC0_WDOG_BIT]};

    AST_DEEP_WRITE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_en && paddr_i == `DSGATE_OFFSET) |=> deep_gate_q == $past(pwdata_i[7:0]))
        else $error("deep gate write lost");
    AST_FAULT_GATED: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (port_access_i && !port_clk_en_o[port_sel_i]) |-> port_fault_o)
        else $error("access to gated port not faulted");
    AST_NO_FAULT_OPEN: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (port_access_i && port_clk_en_o[port_sel_i]) |-> !port_fault_o)
        else $error("fault on clocked port");
    AST_RESERVED_ZERO: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (src0_q & ~`SRC0_MASK) == 32'h0 && prdata_o[31:17] == 15'h0)
        else $error("reserved bits nonzero");
    AST_MASKED_WRITE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_en && paddr_i == `SRC0_OFFSET && !capability_mask_1_i[3])
        |=> src0_q[3] == $past(src0_q[3]))
        else $error("masked reset bit changed");
    AST_WDOG_HELD: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        src0_q[3] |-> unit_reset_o.wdog)
        else $error("watchdog reset not held");
    AST_HIB_HELD: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        src0_q[6] |-> unit_reset_o.hibernation_reset)
        else $error("hibernation reset not held");
    AST_CONV_HELD: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        src0_q[16] |-> unit_reset_o.conv)
        else $error("converter reset not held");
    AST_UNMAPPED_ERR: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (acc_en && paddr_i != `SRC0_OFFSET && paddr_i != `DSGATE_OFFSET) |-> pslverr_o)
        else $error("unmapped access without error");
    AST_GATE_RESERVED: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        prdata_o[31:17] == 15'h0 && (src0_q & 32'hfffe_ffb7) == 32'h0)
        else $error("reserved reset bits set");
    AST_RESET_VALUE: assert property (@(posedge ref_clk_i)
        $rose(arst_n_i) |-> deep_gate_q == 8'h00 && src0_q == 32'h0)
        else $error("reset values wrong");
    AST_RUN_MODE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (mode_i == PM_RUN) [*2] |-> port_clk_en_o == $past(run_port_clock_gate_i))
        else $error("run mode enable wrong");
    AST_SLEEP_ACG: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (mode_i == PM_SLEEP && auto_clock_gating_i) |=>
        port_clk_en_o == $past(sleep_port_clock_gate_i))
        else $error("sleep gate not applied");

    COV_DEEP_WR: cover property (@(posedge ref_clk_i) wr_en && paddr_i == `DSGATE_OFFSET);
    COV_SRC_WR: cover property (@(posedge ref_clk_i) wr_en && paddr_i == `SRC0_OFFSET);
    COV_FAULT: cover property (@(posedge ref_clk_i) port_fault_o);
    COV_DEEP_MODE: cover property (@(posedge ref_clk_i) mode_i == PM_DEEP && auto_clock_gating_i);
endmodule
`default_nettype wire

// ===== clk_gate_map.svh
// Register map, field positions and reset values of the clock gate block.
// Included by the package and the design files; definitions only.
`ifndef CLK_GATE_MAP_SVH
`define CLK_GATE_MAP_SVH

`define SRC0_OFFSET       12'h040
`define DSGATE_OFFSET     12'h128
`define SRC0_RESET        32'h0000_0000
`define DSGATE_RESET      32'h0000_0000
`define DSGATE_MASK       32'h0000_00ff
`define SRC0_MASK         32'h0001_0048
`define SRC0_CONV_BIT     16
`define SRC0_HIB_BIT      6
`define SRC0_WDOG_BIT     3
`define NUM_PORTS         8
`define ADDR_W            12

`endif

// ===== clk_gate_pkg.sv
// Types shared by the clock gate block and its gate selector.
// Assumes the map header is on the include path.
`include "clk_gate_map.svh"
package clk_gate_pkg;
    typedef enum logic [1:0] {
        PM_RUN,
        PM_SLEEP,
        PM_DEEP
    } power_mode_t;

    typedef struct packed {
        logic [`NUM_PORTS-1:0] run_gate;
        logic [`NUM_PORTS-1:0] sleep_gate;
        logic [`NUM_PORTS-1:0] deep_gate;
    } gate_set_t;

    typedef struct packed {
        logic conv;
        logic hibernation_reset;
        logic wdog;
    } unit_reset_t;
endpackage

// ===== gate_select.sv
// Picks the port clock enables for the current power mode.
// Assumes the mode and the auto gating bit are synchronous to ref_clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "clk_gate_map.svh"
module gate_select
    import clk_gate_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  arst_n_i,
    input  wire clk_gate_pkg::power_mode_t mode_i,
    input  wire logic                  auto_clock_gating_i,
    input  wire clk_gate_pkg::gate_set_t   gates_i,
    output logic [`NUM_PORTS-1:0]      enable_o
);
    import clk_gate_pkg::*;

    logic [`NUM_PORTS-1:0] enable_d;
    logic [`NUM_PORTS-1:0] enable_q;

    always_comb
    begin
        case (mode_i)
            PM_RUN:   enable_d = gates_i.run_gate;
            PM_SLEEP: enable_d = auto_clock_gating_i ? gates_i.sleep_gate
                                                     : gates_i.run_gate;
            PM_DEEP:  enable_d = auto_clock_gating_i ? gates_i.deep_gate
                                                     : gates_i.run_gate;
            default:  enable_d = gates_i.run_gate;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            enable_q <= '0;
        else
            enable_q <= enable_d;
    end

    assign enable_o = enable_q;

    AST_DEEP_USES_DEEP_GATE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (mode_i == PM_DEEP && auto_clock_gating_i) |=> enable_o == $past(gates_i.deep_gate))
        else $error("deep sleep enable not from deep gate");
    AST_NO_ACG_RUN_GATE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !auto_clock_gating_i |=> enable_o == $past(gates_i.run_gate))
        else $error("without auto gating run gate must apply");
endmodule
`default_nettype wire

// ===== deep_sleep_gate_and_soft_reset_tb.sv
// Self-checking testbench for clk_gate_ctl.
// Assumes the map header and clk_gate_pkg are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "clk_gate_map.svh"
module deep_sleep_gate_and_soft_reset_tb;
    import clk_gate_pkg::*;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] m;
        power_mode_t mo;
        logic        g;
        logic [31:0] rd;
        logic [7:0]  en;
    } row_t;
    localparam row_t ROWS [8] = '{
        '{12'h128, 32'hffff_ffff, 32'h0, PM_DEEP, 1'b1, 32'h0000_00ff, 8'hff},
        '{12'h128, 32'h0000_005a, 32'h0, PM_DEEP, 1'b1, 32'h0000_005a, 8'h5a},
        '{12'h128, 32'h0000_005a, 32'h0, PM_DEEP, 1'b0, 32'h0000_005a, 8'h0f},
        '{12'h128, 32'h0000_005a, 32'h0, PM_SLEEP, 1'b1, 32'h0000_005a, 8'h33},
        '{12'h128, 32'h0000_005a, 32'h0, PM_RUN, 1'b1, 32'h0000_005a, 8'h0f},
        '{12'h040, 32'hffff_ffff, 32'hffff_ffff, PM_RUN, 1'b1, 32'h0001_0048, 8'h0f},
        '{12'h040, 32'h0, 32'h0000_0008, PM_RUN, 1'b1, 32'h0001_0040, 8'h0f},
        '{12'h040, 32'h0, 32'hffff_ffff, PM_RUN, 1'b1, 32'h0, 8'h0f}};
    logic clk, arst_n, psel, penable, pwrite, auto_clock_gating, pacc, pready, perr, fault;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, cap, rd;
    logic [2:0]   port;
    logic [7:0]   en;
    power_mode_t  mode;
    unit_reset_t  urst;
    int fails, checked, cyc;
    logic e;
    localparam logic [7:0] DEEP_SET = 8'h5a;
    clk_gate_ctl i_dut (.ref_clk_i(clk), .arst_n_i(arst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .mode_i(mode),
        .auto_clock_gating_i(auto_clock_gating), .run_port_clock_gate_i(8'h0f),
        .sleep_port_clock_gate_i(8'h33), .capability_mask_1_i(cap),
        .port_access_i(pacc), .port_sel_i(port), .port_fault_o(fault),
        .port_clk_en_o(en), .unit_reset_o(urst));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string s);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t %s got %h want %h", $time, s, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp, input string s);
        chk_word({31'h0, got}, {31'h0, exp}, s);
    endtask
    // One APB transfer; entered and left just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        e = perr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            give_verdict();
        end
    end
    initial
    begin
        {arst_n, psel, penable, pwrite, auto_clock_gating, pacc, paddr, pwdata, cap, port} = '0;
        mode = PM_RUN;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, `DSGATE_OFFSET, 32'h0);
        chk_word(rd, 32'h0, "gate reset");
        apb(1'b0, `SRC0_OFFSET, 32'h0);
        chk_word(rd, 32'h0, "soft reset reset");
        foreach (ROWS[i])
        begin
            mode <= ROWS[i].mo;
            auto_clock_gating <= ROWS[i].g;
            cap <= ROWS[i].m;
            apb(1'b1, ROWS[i].a, ROWS[i].d);
            apb(1'b0, ROWS[i].a, 32'h0);
            chk_word(rd, ROWS[i].rd, "readback");
            chk_word({24'h0, en}, {24'h0, ROWS[i].en}, "enables");
            if (ROWS[i].a == `SRC0_OFFSET)
                chk_word({29'h0, urst}, {29'h0, ROWS[i].rd[16], ROWS[i].rd[6],
                    ROWS[i].rd[3]}, "unit resets");
        end
        $display("table done");
        mode <= PM_DEEP;
        // Enables are registered: let the deep gate settle first
        repeat (2) @(posedge clk);
        for (int k = 0; k < 8; k++)
        begin
            port <= k[2:0];
            pacc <= 1'b1;
            @(negedge clk);
            chk_flag(fault, !DEEP_SET[k], "port fault");
            @(posedge clk);
        end
        pacc <= 1'b0;
        $display("fault done");
        apb(1'b0, 12'h044, 32'h0);
        chk_flag(e, 1'b1, "unmapped error");
        chk_word(rd, 32'h0, "unmapped read");
        apb(1'b0, `SRC0_OFFSET, 32'h0);
        apb(1'b1, `SRC0_OFFSET, rd | 32'h0000_0008);
        apb(1'b0, `SRC0_OFFSET, 32'h0);
        chk_word(rd, 32'h0000_0008, "read modify write");
        apb(1'b1, `SRC0_OFFSET, 32'h0000_0048);
        arst_n <= 1'b0;
        @(negedge clk);
        chk_word({21'h0, en, urst}, 32'h0, "outputs in reset");
        @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, `DSGATE_OFFSET, 32'h0);
        chk_word(rd, 32'h0, "gate after reset");
        apb(1'b0, `SRC0_OFFSET, 32'h0);
        chk_word(rd, 32'h0, "soft reset after reset");
        $display("reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
